// [common/boot_cfg_pkg.sv]
/*
  Shared constants and types for the chip reset and boot-configuration block:
  register map, reset values, strap layout, clock-mode decoding and counts.
  Assumes a 32-bit APB register port and a single 25 MHz reference clock.
*/
package boot_cfg_pkg;

  // Register map, byte addresses on APB
  localparam logic [11:0] ADDR_PAD_DRIVE   = 12'h000;
  localparam logic [11:0] ADDR_PAD_SLEW    = 12'h004;
  localparam logic [11:0] ADDR_GPIO_SEL    = 12'h008;
  localparam logic [11:0] ADDR_BOOT_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_SYS_CLOCK_OUT_CTRL = 12'h010;

  // Pad defaults: a cleared bit is the 2 mA drive, a cleared slew bit is fast
  localparam logic [31:0] PAD_DRIVE_RST    = 32'h0000_0000;
  localparam logic [31:0] PAD_SLEW_RST     = 32'h0000_0000;
  localparam logic [31:0] GPIO_SEL_RST     = 32'h0000_0000;
  localparam logic        SYS_CLOCK_OUT_EN_RST    = 1'b1;

  // Boot status field positions
  localparam int STAT_CLK_MODE_LSB = 0;
  localparam int STAT_CRYSTAL_BIT  = 2;
  localparam int STAT_RESET_CONFIG_PIN_BIT     = 3;
  localparam int STAT_TEST_BIT     = 4;
  localparam int STAT_PLL_EN_BIT   = 5;
  localparam int STAT_SRC_LSB      = 6;
  localparam int STAT_FLASH_BIT    = 8;
  localparam int STAT_RESET_OUT_N_BIT     = 9;

  // Reset timing in reference-clock cycles
  localparam int          RESET_IN_N_MIN_CYCLES = 8;
  localparam int          RESET_OUT_N_CYCLES     = 1024;
  localparam logic [3:0]  RESET_IN_N_CNT_MAX    = 4'(RESET_IN_N_MIN_CYCLES);
  localparam logic [10:0] RESET_OUT_N_CNT_MAX    = 11'(RESET_OUT_N_CYCLES);

  typedef enum logic [1:0] {
    SRC_EXT_OSC = 2'b00,
    SRC_ONCHIP  = 2'b01,
    SRC_CRYSTAL = 2'b11
  } clk_src_e;

  typedef enum logic [1:0] {
    MODE_NOPLL_OSC  = 2'b00,
    MODE_NOPLL_CRYSTAL_PIN = 2'b01,
    MODE_PLL_OSC    = 2'b10,
    MODE_PLL_CRYSTAL_PIN   = 2'b11
  } clk_mode_e;

  // Strap pins travel and are captured together
  typedef struct packed {
    logic [1:0] clock_mode_sel;
    logic       crystal_pin;
    logic       reset_config_pin;
    logic       test_pin;
  } strap_s;

  localparam strap_s STRAP_RST = '{clock_mode_sel: 2'b00, crystal_pin: 1'b0,
                                   reset_config_pin: 1'b0, test_pin: 1'b0};

  typedef struct packed {
    logic     pll_en;
    clk_src_e src;
  } clk_cfg_s;

endpackage : boot_cfg_pkg

// [rtl/reset_and_boot_mode_select.sv]
/*
  Chip reset filter, reset-out stretcher, boot strap capture, clock-mode
  decode, clock-out generation and pad default registers behind APB.
  Assumes the reset pin and strap pins are asynchronous board levels and
  that REF_CLK_IN is the CPU clock; SYS_RST_IN is a synchronous power-on reset.
*/

module reset_and_boot_mode_select
  import boot_cfg_pkg::*;
(
  input  wire logic                  REF_CLK_IN,
  input  wire logic                  SYS_RST_IN,
  input  wire logic                  PSEL_IN,
  input  wire logic                  PENABLE_IN,
  input  wire logic                  PWRITE_IN,
  input  wire logic [11:0]           PADDR_IN,
  input  wire logic [31:0]           PWDATA_IN,
  output logic                       PREADY_OUT,
  output logic [31:0]                PRDATA_OUT,
  output logic                       PSLVERR_OUT,
  input  wire logic                  RESET_IN_N_IN,
  input  wire boot_cfg_pkg::strap_s  STRAP_IN,
  output logic                       RESET_OUT_N_OUT,
  output logic                       CORE_RESET_OUT,
  output logic                       SYS_CLOCK_OUT,
  output logic                       PLL_ENABLE_OUT,
  output boot_cfg_pkg::clk_src_e     CLOCK_SOURCE_OUT,
  output logic                       FLASH_PROG_MODE_OUT,
  output logic [31:0]                PAD_DRIVE_CTRL_OUT,
  output logic [31:0]                PAD_SLEW_CTRL_OUT,
  output logic [31:0]                PAD_PULLUP_EN_OUT
);
  import boot_cfg_pkg::*;

  function automatic clk_cfg_s boot_decode(input logic [1:0] mode, input logic crystal);
    clk_cfg_s cfg;
    cfg.pll_en = 1'b0;
    cfg.src    = SRC_EXT_OSC;
    case (clk_mode_e'(mode))
      MODE_NOPLL_OSC:
      begin
        cfg.pll_en = 1'b0;
        cfg.src    = crystal ? SRC_ONCHIP : SRC_EXT_OSC;
      end
      MODE_NOPLL_CRYSTAL_PIN:
      begin
        cfg.pll_en = 1'b0;
        cfg.src    = SRC_CRYSTAL;
      end
      MODE_PLL_OSC:
      begin
        cfg.pll_en = 1'b1;
        cfg.src    = crystal ? SRC_ONCHIP : SRC_EXT_OSC;
      end
      MODE_PLL_CRYSTAL_PIN:
      begin
        cfg.pll_en = 1'b1;
        cfg.src    = SRC_CRYSTAL;
      end
      default:
      begin
        cfg.pll_en = 1'b0;
        cfg.src    = SRC_EXT_OSC;
      end
    endcase
    return cfg;
  endfunction : boot_decode

  function automatic logic addr_known(input logic [11:0] addr);
    return (addr == ADDR_PAD_DRIVE) || (addr == ADDR_PAD_SLEW) ||
           (addr == ADDR_GPIO_SEL) || (addr == ADDR_BOOT_STATUS) ||
           (addr == ADDR_SYS_CLOCK_OUT_CTRL);
  endfunction : addr_known

  // Synchronisers; the first stages feed only the second stages
  logic        rstin_s1_r;
  logic        rstin_s2_r;
  strap_s      strap_s1_r;
  strap_s      strap_s2_r;

  logic [3:0]  low_cnt_r;
  logic [3:0]  low_cnt_nxt;
  logic        rst_src_r;
  logic        rst_src_nxt;
  logic [10:0] reset_out_n_cnt_r;
  logic        reset_out_n_n_r;
  logic        core_rst_r;
  logic        ctrl_rst;

  strap_s      strap_cap_r;
  clk_cfg_s    clk_cfg_r;
  logic        flash_prog_r;
  logic        sys_clock_out_r;
  logic        sys_clock_out_en_r;

  logic [31:0] pad_drive_r;
  logic [31:0] pad_slew_r;
  logic [31:0] gpio_sel_r;
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic [31:0] rd_mux;
  logic        wr_fire;

  always_ff @(posedge REF_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      rstin_s1_r <= 1'b1;
      rstin_s2_r <= 1'b1;
      strap_s1_r <= STRAP_RST;
      strap_s2_r <= STRAP_RST;
    end
    else
    begin
      rstin_s1_r <= RESET_IN_N_IN;
      rstin_s2_r <= rstin_s1_r;
      strap_s1_r <= STRAP_IN;
      strap_s2_r <= strap_s1_r;
    end
  end

  // Short glitches on the reset pin are filtered by the low-cycle count
  always_comb
  begin
    if (rstin_s2_r)
      low_cnt_nxt = 4'h0;
    else if (low_cnt_r == RESET_IN_N_CNT_MAX)
      low_cnt_nxt = RESET_IN_N_CNT_MAX;
    else
      low_cnt_nxt = low_cnt_r + 4'h1;
    rst_src_nxt = (low_cnt_nxt == RESET_IN_N_CNT_MAX);
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      low_cnt_r <= 4'h0;
      rst_src_r <= 1'b1;
    end
    else
    begin
      low_cnt_r <= low_cnt_nxt;
      rst_src_r <= rst_src_nxt;
    end
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (SYS_RST_IN)
      core_rst_r <= 1'b1;
    else
      core_rst_r <= rst_src_r;
  end

  // Reset-out stretch after the reset source ends
  always_ff @(posedge REF_CLK_IN)
  begin
    if (SYS_RST_IN || rst_src_r)
    begin
      reset_out_n_cnt_r <= 11'h000;
      reset_out_n_n_r   <= 1'b0;
    end
    else if (reset_out_n_cnt_r != RESET_OUT_N_CNT_MAX)
    begin
      reset_out_n_cnt_r <= reset_out_n_cnt_r + 11'h001;
      reset_out_n_n_r   <= (reset_out_n_cnt_r == RESET_OUT_N_CNT_MAX - 11'h001);
    end
  end

  // Straps are taken once, on the edge where the reset source releases
  always_ff @(posedge REF_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      strap_cap_r  <= STRAP_RST;
      clk_cfg_r    <= '{pll_en: 1'b0, src: SRC_EXT_OSC};
      flash_prog_r <= 1'b0;
    end
    else if (rst_src_r && !rst_src_nxt)
    begin
      strap_cap_r  <= strap_s2_r;
      clk_cfg_r    <= boot_decode(strap_s2_r.clock_mode_sel, strap_s2_r.crystal_pin);
      flash_prog_r <= strap_s2_r.reset_config_pin && !strap_s2_r.test_pin;
    end
  end

  // Clock-out toggles every rising edge: a registered copy of the system clock at half rate,
  // since a flip-flop output cannot reproduce the clock edge for edge
  always_ff @(posedge REF_CLK_IN)
  begin
    if (SYS_RST_IN)
      sys_clock_out_r <= 1'b0;
    else if (sys_clock_out_en_r)
      sys_clock_out_r <= !sys_clock_out_r;
    else
      sys_clock_out_r <= 1'b0;
  end

  // Pad and control registers also return to defaults on a pin reset
  assign ctrl_rst = SYS_RST_IN || core_rst_r;
  assign wr_fire  = PSEL_IN && PENABLE_IN && pready_r && PWRITE_IN && addr_known(PADDR_IN);

  always_ff @(posedge REF_CLK_IN)
  begin
    if (ctrl_rst)
    begin
      pad_drive_r <= PAD_DRIVE_RST;
      pad_slew_r  <= PAD_SLEW_RST;
    end
    else if (wr_fire && PADDR_IN == ADDR_PAD_DRIVE)
      pad_drive_r <= PWDATA_IN;
    else if (wr_fire && PADDR_IN == ADDR_PAD_SLEW)
      pad_slew_r  <= PWDATA_IN;
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (ctrl_rst)
      gpio_sel_r <= GPIO_SEL_RST;
    else if (wr_fire && PADDR_IN == ADDR_GPIO_SEL)
      gpio_sel_r <= PWDATA_IN;
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (ctrl_rst)
      sys_clock_out_en_r <= SYS_CLOCK_OUT_EN_RST;
    else if (wr_fire && PADDR_IN == ADDR_SYS_CLOCK_OUT_CTRL)
      sys_clock_out_en_r <= PWDATA_IN[0];
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (PADDR_IN)
      ADDR_PAD_DRIVE:   rd_mux = pad_drive_r;
      ADDR_PAD_SLEW:    rd_mux = pad_slew_r;
      ADDR_GPIO_SEL:    rd_mux = gpio_sel_r;
      ADDR_SYS_CLOCK_OUT_CTRL: rd_mux = {31'h0000_0000, sys_clock_out_en_r};
      ADDR_BOOT_STATUS:
      begin
        rd_mux[STAT_CLK_MODE_LSB +: 2] = strap_cap_r.clock_mode_sel;
        rd_mux[STAT_CRYSTAL_BIT]       = strap_cap_r.crystal_pin;
        rd_mux[STAT_RESET_CONFIG_PIN_BIT]          = strap_cap_r.reset_config_pin;
        rd_mux[STAT_TEST_BIT]          = strap_cap_r.test_pin;
        rd_mux[STAT_PLL_EN_BIT]        = clk_cfg_r.pll_en;
        rd_mux[STAT_SRC_LSB +: 2]      = clk_cfg_r.src;
        rd_mux[STAT_FLASH_BIT]         = flash_prog_r;
        rd_mux[STAT_RESET_OUT_N_BIT]          = reset_out_n_n_r;
      end
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // One wait state: pready rises in the second access cycle, data registered with it
  always_ff @(posedge REF_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else if (PSEL_IN && PENABLE_IN && !pready_r)
    begin
      pready_r  <= 1'b1;
      prdata_r  <= PWRITE_IN ? 32'h0000_0000 : rd_mux;
      pslverr_r <= !addr_known(PADDR_IN);
    end
    else
    begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
  end

  assign PREADY_OUT          = pready_r;
  assign PRDATA_OUT          = prdata_r;
  assign PSLVERR_OUT         = pslverr_r;
  assign RESET_OUT_N_OUT     = reset_out_n_n_r;
  assign CORE_RESET_OUT      = core_rst_r;
  assign SYS_CLOCK_OUT       = sys_clock_out_r;
  assign PLL_ENABLE_OUT      = clk_cfg_r.pll_en;
  assign CLOCK_SOURCE_OUT    = clk_cfg_r.src;
  assign FLASH_PROG_MODE_OUT = flash_prog_r;
  assign PAD_DRIVE_CTRL_OUT  = pad_drive_r;
  assign PAD_SLEW_CTRL_OUT   = pad_slew_r;
  assign PAD_PULLUP_EN_OUT   = gpio_sel_r;

endmodule : reset_and_boot_mode_select

// [test/boot_sel_properties.sv]
/* Checker of reset timing, strap decode and APB answer, bound to the block.
   Sees only the block's ports; assumes one clock and a synchronous reset. */
module boot_sel_props
  import boot_cfg_pkg::*;
(
  input wire logic                   REF_CLK_IN,
  input wire logic                   SYS_RST_IN,
  input wire logic                   PSEL_IN,
  input wire logic                   PENABLE_IN,
  input wire logic                   PREADY_OUT,
  input wire logic                   RESET_IN_N_IN,
  input wire boot_cfg_pkg::strap_s   STRAP_IN,
  input wire logic                   RESET_OUT_N_OUT,
  input wire logic                   CORE_RESET_OUT,
  input wire logic                   PLL_ENABLE_OUT,
  input wire boot_cfg_pkg::clk_src_e CLOCK_SOURCE_OUT,
  input wire logic                   FLASH_PROG_MODE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] low_cnt_r;
  // Low reset-out cycles since core reset ended; a delay chain that long would be too slow
  always_ff @(posedge REF_CLK_IN)
    low_cnt_r <= (SYS_RST_IN || CORE_RESET_OUT) ? 11'h000 : low_cnt_r + 11'(!RESET_OUT_N_OUT);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  property p_answer;
    $rose(PENABLE_IN) && PSEL_IN |=> PREADY_OUT ##1 !PREADY_OUT;
  endproperty
  a_answer: assert property (p_answer) else $error("APB answer not one wait state");
  property p_reset_out_n_low;
    CORE_RESET_OUT |-> !RESET_OUT_N_OUT;
  endproperty
  a_reset_out_n_low: assert property (p_reset_out_n_low) else $error("reset out high in reset");
  property p_reset_out_n_len;
    $rose(RESET_OUT_N_OUT) |-> low_cnt_r == 11'(RESET_OUT_N_CYCLES - 1);
  endproperty
  a_reset_out_n_len: assert property (p_reset_out_n_len) else $error("reset out stretch wrong");
  property p_pin;
    $rose(CORE_RESET_OUT) |-> !$past(RESET_IN_N_IN, 5) && !$past(RESET_IN_N_IN, 10);
  endproperty
  a_pin: assert property (p_pin) else $error("core reset without long pin low");
  property p_pll;
    $fell(CORE_RESET_OUT) |=> PLL_ENABLE_OUT == STRAP_IN.clock_mode_sel[1];
  endproperty
  a_pll: assert property (p_pll) else $error("pll enable wrong");
  property p_src;
    $fell(CORE_RESET_OUT) |=> CLOCK_SOURCE_OUT == (STRAP_IN.clock_mode_sel[0] ? SRC_CRYSTAL
      : STRAP_IN.crystal_pin ? SRC_ONCHIP : SRC_EXT_OSC);
  endproperty
  a_src: assert property (p_src) else $error("clock source wrong");
  property p_flash;
    $fell(CORE_RESET_OUT) |=> FLASH_PROG_MODE_OUT == (STRAP_IN.reset_config_pin
      && !STRAP_IN.test_pin);
  endproperty
  a_flash: assert property (p_flash) else $error("flash mode wrong");
  property p_hold;
    !CORE_RESET_OUT && !$past(CORE_RESET_OUT) |-> $stable(PLL_ENABLE_OUT)
      && $stable(CLOCK_SOURCE_OUT) && $stable(FLASH_PROG_MODE_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("boot choice moved");
endmodule : boot_sel_props

bind reset_and_boot_mode_select boot_sel_props boot_sel_props_inst
(
  .REF_CLK_IN, .SYS_RST_IN, .PSEL_IN, .PENABLE_IN, .PREADY_OUT, .RESET_IN_N_IN, .STRAP_IN,
  .RESET_OUT_N_OUT, .CORE_RESET_OUT, .PLL_ENABLE_OUT, .CLOCK_SOURCE_OUT, .FLASH_PROG_MODE_OUT
);

// [test/board_model.sv]
/* Board model: pulls the reset pin low for a commanded number of clocks
   and presents the strap levels. Assumes the bench's clock. */
module board_model
  import boot_cfg_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 go_in,
  input  wire logic [7:0]           low_len_in,
  input  wire boot_cfg_pkg::strap_s strap_in,
  output logic                      reset_in_n_out,
  output boot_cfg_pkg::strap_s      strap_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_r = 8'h00;
  initial strap_out = STRAP_RST;
  // Straps change only with a new pulse, so they are steady long before release
  always @(posedge clk_in)
  begin
    if (go_in)
    begin
      left_r <= low_len_in;
      strap_out <= strap_in;
    end
    else if (left_r != 8'h00)
      left_r <= left_r - 8'h01;
  end
  assign reset_in_n_out = (left_r == 8'h00);
endmodule : board_model

// [test/tb_top.sv]
/* Self-checking bench for the reset and boot-mode block.
   Drives APB and the board model from one 25 MHz clock. */
module tb_top
  import boot_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        REF_CLK_IN = 1'b0, SYS_RST_IN = 1'b1, PSEL_IN = 1'b0;
  logic        PENABLE_IN = 1'b0, PWRITE_IN = 1'b0, go = 1'b0;
  logic [11:0] PADDR_IN = 12'h000;
  logic [31:0] PWDATA_IN = 32'h0000_0000;
  logic [7:0]  len = 8'h00;
  logic        PREADY_OUT, PSLVERR_OUT, RESET_IN_N_IN, RESET_OUT_N_OUT, CORE_RESET_OUT;
  logic        SYS_CLOCK_OUT, PLL_ENABLE_OUT, FLASH_PROG_MODE_OUT;
  logic [31:0] PRDATA_OUT, PAD_DRIVE_CTRL_OUT, PAD_SLEW_CTRL_OUT, PAD_PULLUP_EN_OUT;
  strap_s      STRAP_IN, strap = STRAP_RST;
  clk_src_e    CLOCK_SOURCE_OUT;
  int          err_total = 0, checks_done = 0;
  strap_s      cases [6] = '{5'h00, 5'h06, 5'h0F, 5'h10, 5'h14, 5'h1A};
  always #20 REF_CLK_IN = ~REF_CLK_IN;
  reset_and_boot_mode_select reset_and_boot_mode_select_inst
  (
    .REF_CLK_IN, .SYS_RST_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN,
    .PREADY_OUT, .PRDATA_OUT, .PSLVERR_OUT, .RESET_IN_N_IN, .STRAP_IN, .RESET_OUT_N_OUT,
    .CORE_RESET_OUT, .SYS_CLOCK_OUT, .PLL_ENABLE_OUT, .CLOCK_SOURCE_OUT,
    .FLASH_PROG_MODE_OUT, .PAD_DRIVE_CTRL_OUT, .PAD_SLEW_CTRL_OUT, .PAD_PULLUP_EN_OUT
  );
  board_model board_model_inst
  (
    .clk_in(REF_CLK_IN), .go_in(go), .low_len_in(len), .strap_in(strap),
    .reset_in_n_out(RESET_IN_N_IN), .strap_out(STRAP_IN)
  );
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Ends with an idle edge so back-to-back calls never drive a signal twice at once
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    PSEL_IN <= 1'b1;
    PWRITE_IN <= wr;
    PADDR_IN <= a;
    PWDATA_IN <= d;
    @(posedge REF_CLK_IN);
    PENABLE_IN <= 1'b1;
    @(posedge REF_CLK_IN);
    // No cycle count is assumed; only the watchdog ends a hung transfer
    while (PREADY_OUT !== 1'b1)
      @(posedge REF_CLK_IN);
    q = PRDATA_OUT;
    e = PSLVERR_OUT;
    PSEL_IN <= 1'b0;
    PENABLE_IN <= 1'b0;
    @(posedge REF_CLK_IN);
  endtask : apb
  task automatic wait_reset_out_n(input logic v);
    for (int n = 0; n < 1200 && RESET_OUT_N_OUT !== v; n++)
      @(posedge REF_CLK_IN);
    chk("reset_out", 32'(RESET_OUT_N_OUT), 32'(v));
  endtask : wait_reset_out_n
  task automatic pulse(input logic [7:0] n);
    go <= 1'b1;
    len <= n;
    @(posedge REF_CLK_IN);
    go <= 1'b0;
  endtask : pulse
  task automatic reg_case;
    logic [31:0] q;
    logic        e;
    logic        c;
    apb(1'b0, ADDR_PAD_DRIVE, 32'h0000_0000, q, e);
    chk("drive_rd", q, PAD_DRIVE_RST);
    apb(1'b1, ADDR_GPIO_SEL, 32'hA5A5_0F0F, q, e);
    chk("pullup", PAD_PULLUP_EN_OUT, 32'hA5A5_0F0F);
    apb(1'b0, 12'hFF0, 32'h0000_0000, q, e);
    chk("slverr", 32'(e), 32'h0000_0001);
    c = SYS_CLOCK_OUT;
    @(posedge REF_CLK_IN);
    chk("sys_clock_out", 32'(SYS_CLOCK_OUT), {31'h0000_0000, ~c});
    apb(1'b0, ADDR_SYS_CLOCK_OUT_CTRL, 32'h0000_0000, q, e);
    chk("sys_clock_out_en_rd", q, {31'h0000_0000, SYS_CLOCK_OUT_EN_RST});
    // A toggling output cannot read low on two edges in a row
    apb(1'b1, ADDR_SYS_CLOCK_OUT_CTRL, 32'h0000_0000, q, e);
    @(posedge REF_CLK_IN);
    chk("sys_clock_out_off", 32'(SYS_CLOCK_OUT), 32'h0000_0000);
    @(posedge REF_CLK_IN);
    chk("sys_clock_out_off", 32'(SYS_CLOCK_OUT), 32'h0000_0000);
  endtask : reg_case
  task automatic short_case;
    pulse(8'h07);
    repeat (20) @(posedge REF_CLK_IN);
    chk("short", 32'(CORE_RESET_OUT), 32'h0000_0000);
    pulse(8'h08);
    wait_reset_out_n(1'b0);
    chk("long", 32'(CORE_RESET_OUT), 32'h0000_0001);
    wait_reset_out_n(1'b1);
  endtask : short_case
  task automatic boot_case(input strap_s s);
    logic [31:0] q;
    logic        e;
    clk_src_e    src;
    logic [31:0] exp;
    apb(1'b1, ADDR_PAD_DRIVE, 32'hFFFF_FFFF, q, e);
    apb(1'b1, ADDR_PAD_SLEW, 32'hFFFF_FFFF, q, e);
    strap <= s;
    pulse(8'h14);
    wait_reset_out_n(1'b0);
    wait_reset_out_n(1'b1);
    src = s.clock_mode_sel[0] ? SRC_CRYSTAL : (s.crystal_pin ? SRC_ONCHIP : SRC_EXT_OSC);
    chk("pll", 32'(PLL_ENABLE_OUT), 32'(s.clock_mode_sel[1]));
    chk("src", 32'(CLOCK_SOURCE_OUT), 32'(src));
    chk("flash", 32'(FLASH_PROG_MODE_OUT), 32'(s.reset_config_pin & ~s.test_pin));
    chk("drive", PAD_DRIVE_CTRL_OUT, PAD_DRIVE_RST);
    chk("slew", PAD_SLEW_CTRL_OUT, PAD_SLEW_RST);
    exp = 32'h0000_0000;
    exp[STAT_CLK_MODE_LSB +: 2] = s.clock_mode_sel;
    exp[STAT_CRYSTAL_BIT] = s.crystal_pin;
    exp[STAT_RESET_CONFIG_PIN_BIT] = s.reset_config_pin;
    exp[STAT_TEST_BIT] = s.test_pin;
    exp[STAT_PLL_EN_BIT] = s.clock_mode_sel[1];
    exp[STAT_SRC_LSB +: 2] = src;
    exp[STAT_FLASH_BIT] = s.reset_config_pin & ~s.test_pin;
    exp[STAT_RESET_OUT_N_BIT] = 1'b1;
    apb(1'b0, ADDR_BOOT_STATUS, 32'h0000_0000, q, e);
    chk("status", q, exp);
  endtask : boot_case
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (20) @(posedge REF_CLK_IN);
    SYS_RST_IN <= 1'b0;
    wait_reset_out_n(1'b1);
    reg_case;
    short_case;
    foreach (cases[i])
      boot_case(cases[i]);
    complete_run;
  end
  initial
  begin
    repeat (20000) @(posedge REF_CLK_IN);
    err_total++;
    complete_run;
  end
endmodule : tb_top
